//--- charger_status_assertions.sv
`timescale 1ns/1ps
`include "charger_status_cfg.svh"
module charger_status_checker
   import charger_status_pkg::*;
(
   input wire logic       clk_sys_in,         // clock
   input wire logic       srst_in,            // reset
   input wire logic       rd_strobe_in,       // read
   input wire logic [7:0] rd_addr_in,         // offset
   input wire logic [7:0] rd_data_out,        // data
   input wire logic       rd_valid_out,       // answer
   input wire logic       therm_hot_in,       // hot
   input wire logic       therm_cold_in,      // cold
   input wire logic       bus_overvoltage_in, // bus ovp
   input wire logic       watchdog_expiry_in  // watchdog
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);
   logic rd_tz, rd_pa, rd_pb, rd_fl;
   assign rd_tz = rd_strobe_in && rd_addr_in == `TEMP_ZONE_STATUS_OFFSET;
   assign rd_pa = rd_strobe_in && rd_addr_in == `PROT_STATUS_A_OFFSET;
   assign rd_pb = rd_strobe_in && rd_addr_in == `PROT_STATUS_B_OFFSET;
   assign rd_fl = rd_strobe_in && rd_addr_in == `EVENT_FLAGS_A_OFFSET;
   answer_timing_a: assert property (rd_strobe_in |=> rd_valid_out)
      else $error("read not answered");
   valid_cause_a: assert property (rd_valid_out |-> $past(rd_strobe_in))
      else $error("answer without read");
   tz_reserved_a: assert property (rd_tz |=> rd_data_out[7:5] == 3'h0)
      else $error("zone reserved bits set");
   pb_reserved_a: assert property (rd_pb |=> rd_data_out[3] == 1'b0
      && rd_data_out[1:0] == 2'h0) else $error("fault b reserved set");
   hot_zone_a: assert property (therm_hot_in[*4] ##0 rd_tz |=> rd_data_out[0])
      else $error("hot zone not shown");
   cold_clear_a: assert property ((!therm_cold_in)[*4] ##0 rd_tz
      |=> !rd_data_out[3]) else $error("cold zone stuck");
   bus_ovp_a: assert property (bus_overvoltage_in[*4] ##0 rd_pa
      |=> rd_data_out[6]) else $error("bus ovp not shown");
   wdog_flag_a: assert property ($rose(watchdog_expiry_in) ##1
      (!rd_fl)[*5] ##1 rd_fl |=> rd_data_out[5]) else $error("wdog flag lost");
   cover property (rd_fl ##2 rd_fl);
   cover property (rd_valid_out && rd_data_out != 8'h00);
   cover property (rd_strobe_in ##1 rd_strobe_in);
endmodule // charger_status_checker

bind charger_status_fault_flag_regs charger_status_checker u_chk (
   .clk_sys_in, .srst_in, .rd_strobe_in, .rd_addr_in, .rd_data_out,
   .rd_valid_out, .therm_hot_in, .therm_cold_in, .bus_overvoltage_in,
   .watchdog_expiry_in);

//--- charger_status_cfg.svh
`ifndef CHARGER_STATUS_CFG_SVH
`define CHARGER_STATUS_CFG_SVH

`define TEMP_ZONE_STATUS_OFFSET 8'h1f
`define PROT_STATUS_A_OFFSET    8'h20
`define PROT_STATUS_B_OFFSET    8'h21
`define EVENT_FLAGS_A_OFFSET    8'h22
`define STATUS_RESET_VALUE      8'h00

`define TZ_BATT_LOW_BIT         4
`define TZ_COLD_BIT             3
`define TZ_COOL_BIT             2
`define TZ_WARM_BIT             1
`define TZ_HOT_BIT              0

`define PA_DISCHARGE_BIT        7
`define PA_BUS_OV_BIT           6
`define PA_BATT_OV_BIT          5
`define PA_IN_OC_BIT            4
`define PA_BATT_OC_BIT          3
`define PA_CONV_OC_BIT          2
`define PA_IN2_OV_BIT           1
`define PA_IN1_OV_BIT           0

`define PB_SHORT_BIT            7
`define PB_SYS_OV_BIT           6
`define PB_SRC_OV_BIT           5
`define PB_SRC_UV_BIT           4
`define PB_TSHUT_BIT            2

`define FL_ILIM_BIT             7
`define FL_VLIM_BIT             6
`define FL_WDOG_BIT             5
`define FL_WEAK_BIT             4
`define FL_PGOOD_BIT            3
`define FL_IN2_BIT              2
`define FL_IN1_BIT              1
`define FL_BUS_BIT              0

`define EDGE_RISE_MASK          8'hf0
`endif

//--- charger_status_fault_flag_regs.sv
`timescale 1ns/1ps
`include "charger_status_cfg.svh"

module charger_status_fault_flag_regs
   import charger_status_pkg::*;
#(
   parameter int SYNC_STAGES = 2
) (
   input  wire logic       clk_sys_in,                 // 125 mhz clock
   input  wire logic       srst_in,                    // sync reset, high
   input  wire logic       rd_strobe_in,               // one-cycle read
   input  wire logic [7:0] rd_addr_in,                 // register offset
   output logic      [7:0] rd_data_out,                // read data
   output logic            rd_valid_out,               // read answer
   input  wire logic       source_mode_batt_low_in,    // battery too low
   input  wire logic       therm_cold_in,              // cold zone
   input  wire logic       therm_cool_in,              // cool zone
   input  wire logic       therm_warm_in,              // warm zone
   input  wire logic       therm_hot_in,               // hot zone
   input  wire logic       batt_discharge_reg_in,      // discharge reg
   input  wire logic       bus_overvoltage_in,         // bus ovp
   input  wire logic       batt_overvoltage_in,        // battery ovp
   input  wire logic       input_overcurrent_in,       // input ocp
   input  wire logic       batt_overcurrent_in,        // battery ocp
   input  wire logic       converter_overcurrent_in,   // converter ocp
   input  wire logic       second_input_overvoltage_in,// input 2 ovp
   input  wire logic       first_input_overvoltage_in, // input 1 ovp
   input  wire logic       system_short_in,            // sys short
   input  wire logic       system_overvoltage_in,      // sys ovp
   input  wire logic       source_mode_overvoltage_in, // source ovp
   input  wire logic       source_mode_undervoltage_in,// source uvp
   input  wire logic       thermal_shutdown_in,        // thermal shutdown
   input  wire logic       input_current_limit_in,     // current reg
   input  wire logic       input_voltage_limit_in,     // voltage reg
   input  wire logic       watchdog_expiry_in,         // watchdog expired
   input  wire logic       weak_source_in,             // weak source
   input  wire logic       power_good_in,              // power good
   input  wire logic       second_input_present_in,    // input 2 present
   input  wire logic       first_input_present_in,     // input 1 present
   input  wire logic       bus_present_in              // bus present
);

   // the synchroniser logic below is built for exactly two flops
   generate
      if (SYNC_STAGES != 2) begin : g_bad_depth
         $error("SYNC_STAGES must be 2");
      end
   endgenerate

   localparam int NUM_MON = 26;

   // position of each monitor level in the synchronised vector
   localparam int IX_BATT_LOW  = 25;
   localparam int IX_COLD      = 24;
   localparam int IX_COOL      = 23;
   localparam int IX_WARM      = 22;
   localparam int IX_HOT       = 21;
   localparam int IX_DISCHARGE = 20;
   localparam int IX_BUS_OV    = 19;
   localparam int IX_BATT_OV   = 18;
   localparam int IX_IN_OC     = 17;
   localparam int IX_BATT_OC   = 16;
   localparam int IX_CONV_OC   = 15;
   localparam int IX_IN2_OV    = 14;
   localparam int IX_IN1_OV    = 13;
   localparam int IX_SHORT     = 12;
   localparam int IX_SYS_OV    = 11;
   localparam int IX_SRC_OV    = 10;
   localparam int IX_SRC_UV    = 9;
   localparam int IX_TSHUT     = 8;

   wire logic [NUM_MON-1:0] mon_raw;
   wire logic [NUM_MON-1:0] mon_lvl;

   assign mon_raw[IX_BATT_LOW]   = source_mode_batt_low_in;
   assign mon_raw[IX_COLD]       = therm_cold_in;
   assign mon_raw[IX_COOL]       = therm_cool_in;
   assign mon_raw[IX_WARM]       = therm_warm_in;
   assign mon_raw[IX_HOT]        = therm_hot_in;
   assign mon_raw[IX_DISCHARGE]  = batt_discharge_reg_in;
   assign mon_raw[IX_BUS_OV]     = bus_overvoltage_in;
   assign mon_raw[IX_BATT_OV]    = batt_overvoltage_in;
   assign mon_raw[IX_IN_OC]      = input_overcurrent_in;
   assign mon_raw[IX_BATT_OC]    = batt_overcurrent_in;
   assign mon_raw[IX_CONV_OC]    = converter_overcurrent_in;
   assign mon_raw[IX_IN2_OV]     = second_input_overvoltage_in;
   assign mon_raw[IX_IN1_OV]     = first_input_overvoltage_in;
   assign mon_raw[IX_SHORT]      = system_short_in;
   assign mon_raw[IX_SYS_OV]     = system_overvoltage_in;
   assign mon_raw[IX_SRC_OV]     = source_mode_overvoltage_in;
   assign mon_raw[IX_SRC_UV]     = source_mode_undervoltage_in;
   assign mon_raw[IX_TSHUT]      = thermal_shutdown_in;
   assign mon_raw[`FL_ILIM_BIT]  = input_current_limit_in;
   assign mon_raw[`FL_VLIM_BIT]  = input_voltage_limit_in;
   assign mon_raw[`FL_WDOG_BIT]  = watchdog_expiry_in;
   assign mon_raw[`FL_WEAK_BIT]  = weak_source_in;
   assign mon_raw[`FL_PGOOD_BIT] = power_good_in;
   assign mon_raw[`FL_IN2_BIT]   = second_input_present_in;
   assign mon_raw[`FL_IN1_BIT]   = first_input_present_in;
   assign mon_raw[`FL_BUS_BIT]   = bus_present_in;

   // monitor levels come from analog domains, so each passes two flops;
   // nothing but the second flop reads the first
   genvar gi;
   generate
      for (gi = 0; gi < NUM_MON; gi++) begin : g_sync
         logic meta_r;
         logic stable_r;
         always_ff @(posedge clk_sys_in) begin
            if (srst_in) begin
               meta_r   <= 1'b0;
               stable_r <= 1'b0;
            end else begin
               meta_r   <= mon_raw[gi];
               stable_r <= meta_r;
            end
         end
         assign mon_lvl[gi] = stable_r;
      end
   endgenerate

   reg_byte_type tz_img;
   reg_byte_type pa_img;
   reg_byte_type pb_img;

   // reserved bits stay at the reset value, so they always read zero
   always_comb begin
      tz_img                   = `STATUS_RESET_VALUE;
      tz_img[`TZ_BATT_LOW_BIT] = mon_lvl[IX_BATT_LOW];
      tz_img[`TZ_COLD_BIT]     = mon_lvl[IX_COLD];
      tz_img[`TZ_COOL_BIT]     = mon_lvl[IX_COOL];
      tz_img[`TZ_WARM_BIT]     = mon_lvl[IX_WARM];
      tz_img[`TZ_HOT_BIT]      = mon_lvl[IX_HOT];
   end

   always_comb begin
      pa_img                    = `STATUS_RESET_VALUE;
      pa_img[`PA_DISCHARGE_BIT] = mon_lvl[IX_DISCHARGE];
      pa_img[`PA_BUS_OV_BIT]    = mon_lvl[IX_BUS_OV];
      pa_img[`PA_BATT_OV_BIT]   = mon_lvl[IX_BATT_OV];
      pa_img[`PA_IN_OC_BIT]     = mon_lvl[IX_IN_OC];
      pa_img[`PA_BATT_OC_BIT]   = mon_lvl[IX_BATT_OC];
      pa_img[`PA_CONV_OC_BIT]   = mon_lvl[IX_CONV_OC];
      pa_img[`PA_IN2_OV_BIT]    = mon_lvl[IX_IN2_OV];
      pa_img[`PA_IN1_OV_BIT]    = mon_lvl[IX_IN1_OV];
   end

   always_comb begin
      pb_img                 = `STATUS_RESET_VALUE;
      pb_img[`PB_SHORT_BIT]  = mon_lvl[IX_SHORT];
      pb_img[`PB_SYS_OV_BIT] = mon_lvl[IX_SYS_OV];
      pb_img[`PB_SRC_OV_BIT] = mon_lvl[IX_SRC_OV];
      pb_img[`PB_SRC_UV_BIT] = mon_lvl[IX_SRC_UV];
      pb_img[`PB_TSHUT_BIT]  = mon_lvl[IX_TSHUT];
   end

   reg_byte_type ev_lvl;
   reg_byte_type ev_prev_r;
   assign ev_lvl = mon_lvl[7:0];

   // the previous level resets low like the synchroniser, so a level
   // already high after reset raises its flag once
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         ev_prev_r <= `STATUS_RESET_VALUE;
      end else begin
         ev_prev_r <= ev_lvl;
      end
   end

   localparam logic [7:0] RISE_ONLY = `EDGE_RISE_MASK;

   logic            flag_read;
   wire logic [7:0] flags;

   assign flag_read = rd_strobe_in && (rd_addr_in == `EVENT_FLAGS_A_OFFSET);

   genvar gf;
   generate
      for (gf = 0; gf < 8; gf++) begin : g_flag
         logic hit;
         logic flag_r;
         if (RISE_ONLY[gf]) begin : g_rise
            assign hit = ev_lvl[gf] & ~ev_prev_r[gf];
         end else begin : g_change
            assign hit = ev_lvl[gf] ^ ev_prev_r[gf];
         end
         // an event in the read cycle survives the clear, so none is lost
         always_ff @(posedge clk_sys_in) begin
            if (srst_in) begin
               flag_r <= 1'b0;
            end else if (hit) begin
               flag_r <= 1'b1;
            end else if (flag_read) begin
               flag_r <= 1'b0;
            end
         end
         assign flags[gf] = flag_r;
      end
   endgenerate

   // read data holds between reads; unmapped offsets answer zero
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         rd_data_out <= `STATUS_RESET_VALUE;
      end else if (rd_strobe_in) begin
         case (rd_addr_in)
            `TEMP_ZONE_STATUS_OFFSET: begin
               rd_data_out <= tz_img;
            end
            `PROT_STATUS_A_OFFSET: begin
               rd_data_out <= pa_img;
            end
            `PROT_STATUS_B_OFFSET: begin
               rd_data_out <= pb_img;
            end
            `EVENT_FLAGS_A_OFFSET: begin
               rd_data_out <= flags;
            end
            default: begin
               rd_data_out <= `STATUS_RESET_VALUE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         rd_valid_out <= 1'b0;
      end else begin
         rd_valid_out <= rd_strobe_in;
      end
   end

endmodule // charger_status_fault_flag_regs

//--- charger_status_pkg.sv
package charger_status_pkg;
   typedef logic [7:0] reg_byte_type;
endpackage

//--- host_read_model.sv
`timescale 1ns/1ps
module host_read_model
   import charger_status_pkg::*;
(
   input  wire logic       clk_sys_in,    // clock
   input  wire logic       rd_valid_in,   // answer
   input  wire logic [7:0] rd_data_in,    // data
   output logic            rd_strobe_out, // read request
   output logic      [7:0] rd_addr_out    // offset
);
   initial begin
      rd_strobe_out = 1'b0;
      rd_addr_out = 8'h00;
   end
   // entered at a falling edge; keep leaves strobe up for a chained read
   task automatic rd(input reg_byte_type a, input bit keep,
                     output reg_byte_type d);
      rd_strobe_out = 1'b1;
      rd_addr_out = a;
      @(negedge clk_sys_in);
      d = (rd_valid_in === 1'b1) ? rd_data_in : 8'hxx;
      if (!keep) begin
         rd_strobe_out = 1'b0;
         rd_addr_out = ~a; // a released address does not hold its value
         @(negedge clk_sys_in);
      end
   endtask
endmodule // host_read_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top
   import charger_status_pkg::*;
;
   logic         clk_sys_in, srst_in, rd_strobe, rd_valid;
   logic   [7:0] rd_addr, rd_data, pa, ev;
   logic   [4:0] tz, pb;
   reg_byte_type got;
   int           errors = 0;
   int           n_checks = 0;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
   charger_status_fault_flag_regs u_dut (
      .clk_sys_in, .srst_in, .rd_strobe_in(rd_strobe),
      .rd_addr_in(rd_addr), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
      .source_mode_batt_low_in(tz[4]), .therm_cold_in(tz[3]),
      .therm_cool_in(tz[2]), .therm_warm_in(tz[1]), .therm_hot_in(tz[0]),
      .batt_discharge_reg_in(pa[7]), .bus_overvoltage_in(pa[6]),
      .batt_overvoltage_in(pa[5]), .input_overcurrent_in(pa[4]),
      .batt_overcurrent_in(pa[3]), .converter_overcurrent_in(pa[2]),
      .second_input_overvoltage_in(pa[1]),
      .first_input_overvoltage_in(pa[0]), .system_short_in(pb[4]),
      .system_overvoltage_in(pb[3]), .source_mode_overvoltage_in(pb[2]),
      .source_mode_undervoltage_in(pb[1]), .thermal_shutdown_in(pb[0]),
      .input_current_limit_in(ev[7]), .input_voltage_limit_in(ev[6]),
      .watchdog_expiry_in(ev[5]), .weak_source_in(ev[4]),
      .power_good_in(ev[3]), .second_input_present_in(ev[2]),
      .first_input_present_in(ev[1]), .bus_present_in(ev[0]));
   host_read_model u_host (.clk_sys_in, .rd_valid_in(rd_valid),
      .rd_data_in(rd_data), .rd_strobe_out(rd_strobe), .rd_addr_out(rd_addr));
   task automatic rdc(input reg_byte_type a, e, input bit keep = 0);
      u_host.rd(a, keep, got);
      `CHK($sformatf("reg %h", a), e, got)
   endtask
   // monitors are synced inside, so let them settle before reading
   task automatic chk_status();
      repeat (4) @(negedge clk_sys_in);
      rdc(8'h1f, {3'h0, tz}, 1);
      rdc(8'h20, pa, 1);
      rdc(8'h20, pa, 1);
      rdc(8'h21, {pb[4:1],1'b0,pb[0],2'h0});
      rdc(8'h21, {pb[4:1],1'b0,pb[0],2'h0});
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      #200us;
      errors++;
      close_out();
   end
   initial begin
      srst_in = 1'b1;
      {tz, pa, pb, ev} = '0;
      repeat (16) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      srst_in = 1'b0;
      @(negedge clk_sys_in);
      for (int a = 8'h1e; a <= 8'h23; a++) rdc(8'(a), 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 9; i++) begin
         tz = (i == 8) ? '1 : 5'(1 << i);
         pa = (i == 8) ? '1 : 8'(1 << i);
         pb = (i == 8) ? '1 : 5'(1 << i);
         chk_status();
      end
      $display("test status bits done");
      for (int j = 0; j < 8; j++) begin
         ev[j] = 1'b1;
         repeat (6) @(negedge clk_sys_in);
         rdc(8'h22, 8'(1 << j));
         rdc(8'h22, 8'h00);
         ev[j] = 1'b0;
         repeat (6) @(negedge clk_sys_in);
         rdc(8'h22, j < 4 ? 8'(1 << j) : 8'h00);
      end
      $display("test event flags done");
      // the edge reaches the flag in the very cycle the read clears it
      ev[0] = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      rdc(8'h22, 8'h00);
      rdc(8'h22, 8'h01);
      $display("test set over clear done");
      close_out();
   end
endmodule // tb_top
